// ### i2c_spi_defs_regs.svh
// register offsets, field positions and reset values of the i2c/spi slave front end
`ifndef I2C_SPI_DEFS_REGS_SVH
`define I2C_SPI_DEFS_REGS_SVH

`define OFS_DATA_PORT 8'h00
`define OFS_ERR_STATUS 8'h04
`define OFS_SLAVE_ID 8'h08
`define OFS_CONTROL 8'h0c
`define UNMAPPED_READ 32'h0000_0000

`define LVL_W 5
`define DP_RX_LVL_LSB 27
`define DP_TX_LVL_LSB 22
`define DP_RX_ACT 21
`define DP_TX_EMPTY 20
`define DP_RX_FULL 19
`define DP_TX_FULL 18
`define DP_RX_EMPTY 17
`define DP_TX_ACT 16
`define DP_RSVD 15:10
`define DP_UNDERRUN 9
`define DP_OVERRUN 8
`define DP_CHAR_LSB 0

`define ES_UNDERRUN 1
`define ES_OVERRUN 0

`define SID_RESET 7'h00

`define CR_EN 0
`define CR_SPI 1
`define CR_I2C 2
`define CR_ABORT 7
`define CR_TX_EN 8
`define CR_RX_EN 9
`define CR_RX_FLAG_INVERT 10
`define CR_TEST 11
`define CR_HOST 12
`define CR_TX_FLAG_INVERT 13

`define SB_TX_FLAG 6
`define SB_RX_FLAG 7

`define BYTE_CNT 4'h8
`define UNDERRUN_FILL 8'h00
`define PINS_IDLE 5'h1b

`endif

// ### i2c_spi_slave_pkg.sv
// types shared by the i2c/spi slave front end
package i2c_spi_slave_pkg;

  typedef enum logic [6:0] {
    st_idle = 7'h01,
    st_addr = 7'h02,
    st_aack = 7'h04,
    st_wr = 7'h08,
    st_wack = 7'h10,
    st_rd = 7'h20,
    st_rack = 7'h40
  } link_state_t;

  typedef struct packed {
    logic tx_flag_invert;
    logic host_access_allow;
    logic fifo_test_mode;
    logic rx_flag_invert;
    logic rx_enable;
    logic tx_enable;
    logic i2c_mode;
    logic spi_mode;
    logic slave_on;
  } control_t;

  typedef struct packed {
    logic sda;
    logic scl;
    logic sclk;
    logic mosi;
    logic cs_n;
  } pins_t;

endpackage

// ### byte_fifo.sv
// synchronous fifo with fill level and flush
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int LW = 5
) (
  input wire logic clk_i, // core clock
  input wire logic rst_i, // synchronous reset
  input wire logic flush_i, // empties the fifo
  input wire logic push_valid_i, // write request
  input wire logic [WIDTH-1:0] push_data_i, // write data
  output logic push_ready_o, // room for a word
  output logic pop_valid_o, // a word is held
  output logic [WIDTH-1:0] pop_data_o, // oldest word
  input wire logic pop_ready_i, // consume oldest word
  output logic [LW-1:0] level_o // words held
);
  // pointers wrap by overflow, so depth must be a power of two
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [LW-1:0] count;
  wire do_push = push_valid_i & push_ready_o;
  wire do_pop = pop_valid_o & pop_ready_i;

  assign push_ready_o = count != LW'(DEPTH);
  assign pop_valid_o = count != '0;
  assign pop_data_o = mem[rd_ptr];
  assign level_o = count;

  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem[wr_ptr] <= push_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || flush_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + LW'(do_push) - LW'(do_pop);
    end
  end
endmodule // byte_fifo

// ### i2c_spi_slave_regs.sv
// wishbone register front end and serial engine of the i2c/spi slave
//
// The address map and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
`include "i2c_spi_defs_regs.svh"
// Function
// - data port read shows rx level in 31:27, tx level in 26:22
// - bit 21 shows receive activity, bit 16 shows transmit activity
// - bits 20 and 17 read one while tx or rx fifo is empty
// - bits 19 and 18 read one while rx or tx fifo is full
// - i2c read with empty tx fifo sets underrun, seen in both registers
// - byte arriving with full rx fifo sets overrun, seen in both registers
// - writing zero to an error bit clears it in both views
// - data port write pushes tx fifo outside test mode, read pops rx fifo
// - status bits five to two ignore writes and read zero
// - seven bit slave identity, reset zero, compared with incoming addresses
// - with host access, incoming address bit zero selects fifo or host registers
// - slave identity has no effect in spi mode
// - control bit 13 picks tx flag sense in host status byte
// - control bit 10 picks rx flag sense in host status byte
// - control bit 12 allows the remote host its register access
// - control bit 11 enables fifo test mode
// - control bits 9 and 8 enable receive and transmit
// - writing one to control bit 7 aborts and flushes both fifos
// - control bits 0, 2, 1 enable slave, i2c mode, spi mode
// - seven bit addressing only, scl is never stretched
module i2c_spi_slave_regs
  import i2c_spi_slave_pkg::*;
#(
  parameter int DEPTH = 16
) (
  input wire logic clk_i, // core clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write enable
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  input wire logic scl_i, // i2c clock pin
  input wire logic sda_i, // i2c data pin level
  output logic sda_o, // i2c data drive level, always low
  output logic sda_oe_o, // i2c data pulled low
  input wire logic sclk_i, // spi clock pin
  input wire logic mosi_i, // spi data in
  input wire logic cs_n_i, // spi select, active low
  output logic miso_o, // spi data out
  output logic miso_oe_o, // spi data out driven
  output logic [7:0] host_ctrl_o // byte last written by the remote host to the host registers
);
  localparam int LW = `LVL_W;

  // pin synchronisers: meta feeds sync only, last gives edges
  pins_t pin_meta;
  pins_t pin_sync;
  pins_t pin_last;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta <= `PINS_IDLE;
      pin_sync <= `PINS_IDLE;
      pin_last <= `PINS_IDLE;
    end else begin
      pin_meta <= '{sda: sda_i, scl: scl_i, sclk: sclk_i, mosi: mosi_i, cs_n: cs_n_i};
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  wire scl_rise = pin_sync.scl & ~pin_last.scl;
  wire scl_fall = ~pin_sync.scl & pin_last.scl;
  wire scl_high = pin_sync.scl & pin_last.scl;
  wire bus_start = scl_high & pin_last.sda & ~pin_sync.sda;
  wire bus_stop = scl_high & ~pin_last.sda & pin_sync.sda;
  wire sclk_rise = pin_sync.sclk & ~pin_last.sclk;
  wire sclk_fall = ~pin_sync.sclk & pin_last.sclk;
  wire spi_sel = ~pin_sync.cs_n;
  wire cs_fall = spi_sel & pin_last.cs_n;

  control_t ctrl;
  logic [6:0] slave_id;
  logic underrun;
  logic overrun;
  link_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] rx_sh;
  logic [7:0] tx_sh;
  logic rw;
  logic nack;
  logic host_sel;
  logic ser_push;
  logic [7:0] ser_byte;

  // fifo wiring
  logic tx_ready;
  logic tx_valid;
  logic [7:0] tx_head;
  logic [LW-1:0] tx_level;
  logic rx_ready;
  logic rx_valid;
  logic [7:0] rx_head;
  logic [LW-1:0] rx_level;

  // bus decode: requests commit at the edge that raises ack
  wire req_new = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr = req_new & wb_we_i;
  wire bus_rd = req_new & ~wb_we_i;
  wire sel_dp = wb_adr_i == `OFS_DATA_PORT;
  wire sel_es = wb_adr_i == `OFS_ERR_STATUS;
  wire sel_sid = wb_adr_i == `OFS_SLAVE_ID;
  wire sel_cr = wb_adr_i == `OFS_CONTROL;
  wire dp_wr = bus_wr & sel_dp & wb_sel_i[0];
  wire dp_rd = bus_rd & sel_dp;
  wire es_wr = bus_wr & sel_es & wb_sel_i[0];
  wire sid_wr = bus_wr & sel_sid & wb_sel_i[0];
  wire cr_wr_lo = bus_wr & sel_cr & wb_sel_i[0];
  wire cr_wr_hi = bus_wr & sel_cr & wb_sel_i[1];
  wire abort = cr_wr_lo & wb_dat_i[`CR_ABORT];

  // mode selection; i2c wins if software sets both
  wire i2c_on = ctrl.slave_on & ctrl.i2c_mode;
  wire spi_on = ctrl.slave_on & ctrl.spi_mode & ~ctrl.i2c_mode;

  // address compare; with host access the low address bit is the selector
  wire addr_hit = ctrl.host_access_allow ? (rx_sh[7:2] == slave_id[6:1])
                                         : (rx_sh[7:1] == slave_id);
  wire host_pick = ctrl.host_access_allow & rx_sh[1];

  // host-visible status byte
  wire tx_empty = ~tx_valid;
  wire tx_full = ~tx_ready;
  wire rx_empty = ~rx_valid;
  wire rx_full = ~rx_ready;
  wire tx_flag = ctrl.tx_flag_invert ? tx_full : tx_empty;
  wire rx_flag = ctrl.rx_flag_invert ? rx_empty : rx_full;
  wire [7:0] status_byte = (8'(tx_flag) << `SB_TX_FLAG) | (8'(rx_flag) << `SB_RX_FLAG);

  // next byte toward the master
  wire i2c_load = i2c_on & scl_fall & ((state == st_aack & rw) | (state == st_rack & ~nack));
  wire spi_byte_end = spi_on & spi_sel & sclk_fall & (bit_cnt == `BYTE_CNT);
  wire spi_load = (spi_on & cs_fall) | spi_byte_end;
  wire byte_load = i2c_load | spi_load;
  wire tx_avail = tx_valid & ctrl.tx_enable;
  wire tx_pop = byte_load & ~host_sel & tx_avail;
  wire [7:0] load_byte = host_sel ? status_byte : (tx_avail ? tx_head : `UNDERRUN_FILL);
  wire underrun_evt = i2c_load & ~host_sel & ~tx_avail;

  // byte from the master
  wire i2c_wr_done = i2c_on & scl_fall & (state == st_wr) & (bit_cnt == `BYTE_CNT);
  wire rx_take = (i2c_wr_done & ~host_sel) | spi_byte_end;
  wire ser_push_next = rx_take & ctrl.rx_enable & ~ctrl.fifo_test_mode;
  // test mode loops bus writes into the rx fifo; serial receive is held off meanwhile
  wire test_push = dp_wr & ctrl.fifo_test_mode;
  wire rx_push = ser_push | test_push;
  wire [7:0] rx_push_data = test_push ? wb_dat_i[7:0] : ser_byte;
  wire overrun_evt = rx_push & ~rx_ready;
  wire tx_push = dp_wr & ~ctrl.fifo_test_mode;

  wire rx_act = (state == st_addr) | (state == st_wr) | (state == st_wack) | (spi_on & spi_sel);
  wire tx_act = (state == st_rd) | (state == st_rack) | (spi_on & spi_sel);

  byte_fifo #(.WIDTH(8), .DEPTH(DEPTH), .LW(LW)) u_tx_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .flush_i(abort),
    .push_valid_i(tx_push),
    .push_data_i(wb_dat_i[7:0]),
    .push_ready_o(tx_ready),
    .pop_valid_o(tx_valid),
    .pop_data_o(tx_head),
    .pop_ready_i(tx_pop),
    .level_o(tx_level)
  );

  byte_fifo #(.WIDTH(8), .DEPTH(DEPTH), .LW(LW)) u_rx_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .flush_i(abort),
    .push_valid_i(rx_push),
    .push_data_i(rx_push_data),
    .push_ready_o(rx_ready),
    .pop_valid_o(rx_valid),
    .pop_data_o(rx_head),
    .pop_ready_i(dp_rd),
    .level_o(rx_level)
  );

  function automatic logic [31:0] pack_control(input control_t c);
    logic [31:0] r;
    r = '0;
    r[`CR_EN] = c.slave_on;
    r[`CR_SPI] = c.spi_mode;
    r[`CR_I2C] = c.i2c_mode;
    r[`CR_TX_EN] = c.tx_enable;
    r[`CR_RX_EN] = c.rx_enable;
    r[`CR_RX_FLAG_INVERT] = c.rx_flag_invert;
    r[`CR_TEST] = c.fifo_test_mode;
    r[`CR_HOST] = c.host_access_allow;
    r[`CR_TX_FLAG_INVERT] = c.tx_flag_invert;
    return r;
  endfunction

  // read values; unlisted bits stay zero
  wire [31:0] dp_value = (32'(rx_level) << `DP_RX_LVL_LSB)
                       | (32'(tx_level) << `DP_TX_LVL_LSB)
                       | (32'(rx_act) << `DP_RX_ACT)
                       | (32'(tx_empty) << `DP_TX_EMPTY)
                       | (32'(rx_full) << `DP_RX_FULL)
                       | (32'(tx_full) << `DP_TX_FULL)
                       | (32'(rx_empty) << `DP_RX_EMPTY)
                       | (32'(tx_act) << `DP_TX_ACT)
                       | (32'(underrun) << `DP_UNDERRUN)
                       | (32'(overrun) << `DP_OVERRUN)
                       | (32'(rx_valid ? rx_head : 8'h00) << `DP_CHAR_LSB);
  wire [31:0] es_value = (32'(underrun) << `ES_UNDERRUN) | (32'(overrun) << `ES_OVERRUN);
  wire [31:0] sid_value = 32'(slave_id);
  wire [31:0] rd_value = sel_dp ? dp_value :
                         sel_es ? es_value :
                         sel_sid ? sid_value :
                         sel_cr ? pack_control(ctrl) : `UNMAPPED_READ;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `UNMAPPED_READ;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      if (bus_rd) begin
        wb_dat_o <= rd_value;
      end
    end
  end

  // software registers; an error event in the clearing cycle keeps the flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= '0;
      slave_id <= `SID_RESET;
      underrun <= 1'b0;
      overrun <= 1'b0;
    end else begin
      underrun <= underrun_evt | (underrun & ~(es_wr & ~wb_dat_i[`ES_UNDERRUN]));
      overrun <= overrun_evt | (overrun & ~(es_wr & ~wb_dat_i[`ES_OVERRUN]));
      if (sid_wr) begin
        slave_id <= wb_dat_i[6:0];
      end
      if (cr_wr_lo) begin
        ctrl.slave_on <= wb_dat_i[`CR_EN];
        ctrl.spi_mode <= wb_dat_i[`CR_SPI];
        ctrl.i2c_mode <= wb_dat_i[`CR_I2C];
      end
      if (cr_wr_hi) begin
        ctrl.tx_enable <= wb_dat_i[`CR_TX_EN];
        ctrl.rx_enable <= wb_dat_i[`CR_RX_EN];
        ctrl.rx_flag_invert <= wb_dat_i[`CR_RX_FLAG_INVERT];
        ctrl.fifo_test_mode <= wb_dat_i[`CR_TEST];
        ctrl.host_access_allow <= wb_dat_i[`CR_HOST];
        ctrl.tx_flag_invert <= wb_dat_i[`CR_TX_FLAG_INVERT];
      end
    end
  end

  // serial engine; sda only ever pulls low, scl is never driven
  always_ff @(posedge clk_i) begin
    if (rst_i || abort) begin
      state <= st_idle;
      bit_cnt <= '0;
      rx_sh <= '0;
      tx_sh <= '0;
      rw <= 1'b0;
      nack <= 1'b0;
      host_sel <= 1'b0;
      sda_oe_o <= 1'b0;
      miso_o <= 1'b0;
      miso_oe_o <= 1'b0;
      ser_push <= 1'b0;
      ser_byte <= '0;
      host_ctrl_o <= '0;
      sda_o <= 1'b0;
    end else begin
      ser_push <= ser_push_next;
      if (rx_take) begin
        ser_byte <= rx_sh;
      end
      if (i2c_wr_done && host_sel) begin
        host_ctrl_o <= rx_sh;
      end
      miso_oe_o <= spi_on & spi_sel;
      if (i2c_on) begin
        if (bus_start) begin
          state <= st_addr;
          bit_cnt <= '0;
          sda_oe_o <= 1'b0;
          host_sel <= 1'b0;
        end else if (bus_stop) begin
          state <= st_idle;
          sda_oe_o <= 1'b0;
        end else begin
          if (scl_rise) begin
            rx_sh <= {rx_sh[6:0], pin_sync.sda};
            bit_cnt <= bit_cnt + 1'b1;
            if (state == st_rack) begin
              nack <= pin_sync.sda;
            end
          end
          if (scl_fall) begin
            case (state)
              st_idle: begin
              end
              st_addr: begin
                if (bit_cnt == `BYTE_CNT) begin
                  if (addr_hit) begin
                    state <= st_aack;
                    sda_oe_o <= 1'b1;
                    rw <= rx_sh[0];
                    host_sel <= host_pick;
                  end else begin
                    state <= st_idle;
                  end
                end
              end
              st_aack: begin
                bit_cnt <= '0;
                if (rw) begin
                  state <= st_rd;
                  tx_sh <= load_byte;
                  sda_oe_o <= ~load_byte[7];
                end else begin
                  state <= st_wr;
                  sda_oe_o <= 1'b0;
                end
              end
              st_wr: begin
                if (bit_cnt == `BYTE_CNT) begin
                  state <= st_wack;
                  sda_oe_o <= 1'b1;
                end
              end
              st_wack: begin
                bit_cnt <= '0;
                state <= st_wr;
                sda_oe_o <= 1'b0;
              end
              st_rd: begin
                if (bit_cnt == `BYTE_CNT) begin
                  state <= st_rack;
                  sda_oe_o <= 1'b0;
                end else begin
                  sda_oe_o <= ~tx_sh[6];
                  tx_sh <= {tx_sh[6:0], 1'b0};
                end
              end
              st_rack: begin
                bit_cnt <= '0;
                if (nack) begin
                  state <= st_idle;
                end else begin
                  state <= st_rd;
                  tx_sh <= load_byte;
                  sda_oe_o <= ~load_byte[7];
                end
              end
              default: begin
                state <= st_idle;
              end
            endcase
          end
        end
      end else begin
        // spi and disabled: identity compare and sda stay out of play
        state <= st_idle;
        sda_oe_o <= 1'b0;
        host_sel <= 1'b0;
        if (!spi_on || !spi_sel) begin
          bit_cnt <= '0;
        end else if (cs_fall) begin
          bit_cnt <= '0;
          tx_sh <= load_byte;
          miso_o <= load_byte[7];
        end else begin
          if (sclk_rise) begin
            rx_sh <= {rx_sh[6:0], pin_sync.mosi};
            bit_cnt <= bit_cnt + 1'b1;
          end
          if (sclk_fall) begin
            if (bit_cnt == `BYTE_CNT) begin
              bit_cnt <= '0;
              tx_sh <= load_byte;
              miso_o <= load_byte[7];
            end else begin
              miso_o <= tx_sh[6];
              tx_sh <= {tx_sh[6:0], 1'b0};
            end
          end
        end
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_rx_level;
    wb_ack_o && $past(dp_rd) |-> wb_dat_o[`DP_RX_LVL_LSB +: `LVL_W] == $past(rx_level);
  endproperty
  a_rx_level: assert property (p_rx_level) else $error("rx level wrong");

  property p_tx_empty;
    wb_ack_o && $past(dp_rd) |-> wb_dat_o[`DP_TX_EMPTY] == $past(tx_empty);
  endproperty
  a_tx_empty: assert property (p_tx_empty) else $error("tx empty flag wrong");

  property p_rx_full;
    wb_ack_o && $past(dp_rd) |-> wb_dat_o[`DP_RX_FULL] == $past(rx_full);
  endproperty
  a_rx_full: assert property (p_rx_full) else $error("rx full flag wrong");

  property p_underrun;
    underrun_evt |=> underrun ##1 (underrun || $past(es_wr));
  endproperty
  a_underrun: assert property (p_underrun) else $error("underrun not held");

  property p_overrun;
    overrun_evt |=> overrun;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not set");

  property p_clear;
    es_wr && !wb_dat_i[`ES_UNDERRUN] && !underrun_evt |=> !underrun;
  endproperty
  a_clear: assert property (p_clear) else $error("underrun not cleared");

  property p_push;
    tx_push && tx_ready && !tx_pop |=> tx_level == $past(tx_level) + 5'h01;
  endproperty
  a_push: assert property (p_push) else $error("tx push lost");

  property p_abort;
    abort |=> tx_level == '0 && rx_level == '0 && state == st_idle;
  endproperty
  a_abort: assert property (p_abort) else $error("abort did not flush");

  property p_spi_quiet;
    spi_on && $past(spi_on) |-> state == st_idle && !sda_oe_o;
  endproperty
  a_spi_quiet: assert property (p_spi_quiet) else $error("i2c active in spi mode");

  property p_tx_gate;
    tx_pop |-> ctrl.tx_enable && tx_valid;
  endproperty
  a_tx_gate: assert property (p_tx_gate) else $error("tx pop while disabled");

  property p_reserved;
    wb_ack_o && $past(sel_dp) && $past(bus_rd) |-> wb_dat_o[`DP_RSVD] == '0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

  c_underrun: cover property (underrun_evt);
  c_rx_push: cover property (ser_push ##1 rx_valid);
  c_addr_ack: cover property (state == st_aack);
  c_spi_byte: cover property (spi_byte_end);
endmodule // i2c_spi_slave_regs

// ### i2c_host_model.sv
// i2c and spi bus master model driving the slave's link pins
`timescale 1ns/1ps
module i2c_host_model (
  output logic scl_o, // link clock, driven by the master only
  output logic sda_oe_o, // high pulls the data line low
  input wire logic sda_i, // resolved data line with pull-up
  output logic sclk_o, // spi clock, idles low, mode 0
  output logic mosi_o, // spi data toward the slave
  output logic cs_n_o, // spi select, active low
  input wire logic miso_i // spi data from the slave
);
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
    sclk_o = 1'b0;
    mosi_o = 1'b1;
    cs_n_o = 1'b1;
  end
  // fixed 200 ns bit time; the clock never waits, as the slave cannot stretch
  task automatic bit_io(input logic b, output logic s);
    scl_o = 1'b0;
    #25 sda_oe_o = ~b;
    #75 scl_o = 1'b1;
    #50 s = sda_i;
    #50;
  endtask
  // the offset keeps every pin change off the core clock edges
  task automatic start;
    #7;
    sda_oe_o = 1'b0;
    scl_o = 1'b1;
    #100 sda_oe_o = 1'b1;
    #100;
  endtask
  task automatic stop;
    scl_o = 1'b0;
    #25 sda_oe_o = 1'b1;
    #75 scl_o = 1'b1;
    #100 sda_oe_o = 1'b0;
    #100;
  endtask
  // 7-bit address then r/w, msb first; address bit zero steers host access
  task automatic put_byte(input logic [7:0] v, output logic ack_n);
    for (int i = 7; i >= 0; i--) bit_io(v[i], ack_n);
    bit_io(1'b1, ack_n);
  endtask
  task automatic get_byte(input logic nack, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      v[i] = s;
    end
    bit_io(nack, s);
  endtask
  // spi frame: the clock stands low outside frames, data sampled on the rise
  task automatic spi_begin;
    #7 cs_n_o = 1'b0;
    #200;
  endtask
  task automatic spi_byte(input logic [7:0] v, output logic [7:0] r);
    #7;
    for (int i = 7; i >= 0; i--) begin
      mosi_o = v[i];
      #100 sclk_o = 1'b1;
      r[i] = miso_i;
      #100 sclk_o = 1'b0;
    end
  endtask
  task automatic spi_end;
    #100 cs_n_o = 1'b1;
    #100;
  endtask
endmodule // i2c_host_model

// ### i2c_spi_slave_regs_tb.sv
// self-checking bench for the i2c/spi slave register front end
`timescale 1ns/1ps
`include "i2c_spi_defs_regs.svh"
module i2c_spi_slave_regs_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat, q;
  logic ack, scl, m_oe, s_oe, sda_line, an;
  logic sclk, mosi, cs_n, miso, miso_oe, sda_lvl;
  logic [7:0] hctl, b;
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;
  // open-drain data line with pull-up
  assign sda_line = ~(m_oe | s_oe);
  always #12.5 clk_i = ~clk_i;
  i2c_spi_slave_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_lvl), .sda_oe_o(s_oe),
    .sclk_i(sclk), .mosi_i(mosi), .cs_n_i(cs_n), .miso_o(miso), .miso_oe_o(miso_oe),
    .host_ctrl_o(hctl));
  i2c_host_model mm_u (.scl_o(scl), .sda_oe_o(m_oe), .sda_i(sda_line), .sclk_o(sclk),
    .mosi_o(mosi), .cs_n_o(cs_n), .miso_i(miso));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      report_and_stop;
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // classic cycle: request held until ack is sampled high, then released
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    wb(1'b0, a, 32'h0000_0000);
    chk(n, e, q);
  endtask
  task automatic i2c_wr(input logic [7:0] a, input logic [7:0] d, input logic ea);
    mm_u.start;
    mm_u.put_byte(a, an);
    chk("addr_ack", 32'(ea), 32'(an));
    if (ea == 1'b0) begin
      mm_u.put_byte(d, an);
      chk("data_ack", 32'h0000_0000, 32'(an));
    end
    mm_u.stop;
  endtask
  task automatic i2c_rd(input logic [7:0] a, input logic [7:0] e);
    mm_u.start;
    mm_u.put_byte(a, an);
    chk("addr_ack", 32'h0000_0000, 32'(an));
    mm_u.get_byte(1'b1, b);
    chk("i2c_byte", 32'(e), 32'(b));
    mm_u.stop;
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rd(`OFS_DATA_PORT, 32'h0012_0000, "dp_reset");
    rd(`OFS_ERR_STATUS, 32'h0000_0000, "es_reset");
    rd(`OFS_SLAVE_ID, 32'h0000_0000, "sid_reset");
    rd(`OFS_CONTROL, 32'h0000_0000, "cr_reset");
    rd(8'h10, 32'h0000_0000, "unmapped");
    wb(1'b1, `OFS_CONTROL, 32'hffff_ffff);
    rd(`OFS_CONTROL, 32'h0000_3f07, "cr_rw");
    wb(1'b1, `OFS_SLAVE_ID, 32'hffff_ffff);
    rd(`OFS_SLAVE_ID, 32'h0000_007f, "sid_rw");
    wb(1'b1, `OFS_CONTROL, 32'h0000_0000);
    $display("test registers done");
    // 17 pushes: the last one meets a full fifo and is dropped
    for (int i = 0; i < 17; i++) wb(1'b1, `OFS_DATA_PORT, 32'(i));
    rd(`OFS_DATA_PORT, 32'h0406_0000, "tx_full");
    wb(1'b1, `OFS_CONTROL, 32'h0000_0080);
    rd(`OFS_DATA_PORT, 32'h0012_0000, "abort");
    wb(1'b1, `OFS_CONTROL, 32'h0000_0800);
    for (int i = 0; i < 17; i++) wb(1'b1, `OFS_DATA_PORT, 32'(i));
    rd(`OFS_DATA_PORT, 32'h8018_0100, "rx_full");
    rd(`OFS_ERR_STATUS, 32'h0000_0001, "es_ovr");
    wb(1'b1, `OFS_ERR_STATUS, 32'h0000_003e);
    rd(`OFS_ERR_STATUS, 32'h0000_0000, "es_clr");
    rd(`OFS_DATA_PORT, 32'h7810_0001, "pop");
    wb(1'b1, `OFS_CONTROL, 32'h0000_0880);
    rd(`OFS_DATA_PORT, 32'h0012_0000, "flush");
    $display("test fifos done");
    wb(1'b1, `OFS_CONTROL, 32'h0000_0305);
    wb(1'b1, `OFS_SLAVE_ID, 32'h0000_002a);
    i2c_wr(8'h54, 8'ha5, 1'b0);
    rd(`OFS_DATA_PORT, 32'h0810_00a5, "i2c_rx");
    i2c_wr(8'h56, 8'h00, 1'b1);
    i2c_rd(8'h55, 8'h00);
    rd(`OFS_ERR_STATUS, 32'h0000_0002, "es_und");
    rd(`OFS_DATA_PORT, 32'h0012_0200, "dp_und");
    wb(1'b1, `OFS_ERR_STATUS, 32'h0000_0000);
    rd(`OFS_ERR_STATUS, 32'h0000_0000, "es_clr2");
    wb(1'b1, `OFS_CONTROL, 32'h0000_1305);
    i2c_wr(8'h56, 8'h5c, 1'b0);
    chk("host_ctrl", 32'h0000_005c, 32'(hctl));
    i2c_rd(8'h57, 8'h40);
    wb(1'b1, `OFS_CONTROL, 32'h0000_3705);
    i2c_rd(8'h57, 8'h80);
    $display("test i2c done");
    // spi mode: the identity must not answer, one byte each way through the fifos
    wb(1'b1, `OFS_CONTROL, 32'h0000_0303);
    i2c_wr(8'h54, 8'h00, 1'b1);
    wb(1'b1, `OFS_DATA_PORT, 32'h0000_003c);
    mm_u.spi_begin;
    rd(`OFS_DATA_PORT, 32'h0033_0000, "spi_busy");
    chk("miso_oe", 32'h0000_0001, 32'(miso_oe));
    mm_u.spi_byte(8'hc3, b);
    chk("spi_byte", 32'h0000_003c, 32'(b));
    mm_u.spi_end;
    chk("miso_oe_off", 32'h0000_0000, 32'(miso_oe));
    chk("sda_o", 32'h0000_0000, 32'(sda_lvl));
    rd(`OFS_DATA_PORT, 32'h0810_00c3, "spi_rx");
    rd(`OFS_ERR_STATUS, 32'h0000_0000, "spi_no_und");
    $display("test spi done");
    report_and_stop;
  end
endmodule // i2c_spi_slave_regs_tb
